/* rtl/rxhop_ctrl.sv */
// rx channel and hop control top with axi4-lite registers
// Function
// - frequency word is integer plus fraction over 2^19, times 2*xtal/outdiv
// - integer and fraction setting define base frequency of channel zero
// - step size held as upper and lower byte settings
// - channel number comes with begin-receive and begin-transmit commands
// - omitted channel argument reuses last supplied channel
// - stored channel starts at zero
// - auto hopping starts at receive entry when enabled
// - hop table holds up to 64 channel entries
// - hopping limited to programmed table size
// - hopping starts at first entry and advances sequentially
// - after last entry wrap to first entry
// - entries equal to 0xFF are skipped
// - rssi, preamble timeout, sync timeout conditions individually enabled
// - first met enabled condition decides stay or hop
// - stay when rssi above threshold, hop when below
// - rssi used unaveraged
// - raw mode allows only rssi condition
// - auto hop turnaround within 115 us
// - manual fast hop turnaround 75 us
// - gpio toggles at each auto hop that does not wrap when configured, holds at a wrap
`timescale 1ns/1ps
`include "rxhop_regs.svh"
module rxhop_ctrl
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] current_rssi,
    input wire logic preamble_timeout,
    input wire logic sync_timeout,
    input wire logic packet_valid,
    input wire logic packet_mode,
    output logic [39:0] synth_freq_word,
    output logic synth_load,
    output logic [15:0] vco_calibration_count,
    output logic vco_count_use,
    output logic rx_active,
    output logic tx_active,
    output logic hop_gpio
);
    typedef struct packed {
        logic awdone;
        logic wdone;
        logic [11:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] integer_divide_value;
        logic [19:0] fractional_divide_value;
        logic [7:0] step_upper;
        logic [7:0] step_lower;
        logic [6:0] table_size;
        logic [3:0] hop_ctrl;
        logic [7:0] signal_strength_threshold;
        logic gpio_en;
        logic [15:0] vco_calibration_count;
        logic [6:0] act_size;
        logic [3:0] act_ctrl;
        logic [7:0] channel;
        logic [5:0] index;
        rxhop_pkg::rxhop_state_t fsm;
        logic [15:0] timer;
        logic fast;
        logic load;
        logic gpio;
    } rxhop_ctrl_state_t;
    rxhop_ctrl_state_t state_reg;
    rxhop_ctrl_state_t state_next;
    logic [7:0] hop_table [0:`RXHOP_TABLE_DEPTH-1];
    logic tbl_we;
    logic [5:0] tbl_waddr;
    logic [7:0] tbl_wdata;
    logic [6:0] lim;
    logic [5:0] nxt;
    logic wrapped;
    logic skip_found;
    logic [6:0] k;
    logic [5:0] cand;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_fire;
    logic met_rssi;
    logic met_pre;
    logic met_sync;
    logic [15:0] auto_cyc;
    logic [15:0] fast_cyc;
    logic [5:0] first_idx;
    logic first_found;
    rxhop_tune_if tune();
    rxhop_freq_calc rxhop_freq_calc_inst
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .tune(tune)
    );
    assign tune.integer_divide_value = state_reg.integer_divide_value;
    assign tune.fractional_divide_value = state_reg.fractional_divide_value;
    assign tune.step = {state_reg.step_upper, state_reg.step_lower};
    assign tune.channel = state_reg.channel;
    assign auto_cyc = 16'(`RXHOP_AUTO_HOP_CYC);
    assign fast_cyc = 16'(`RXHOP_FAST_HOP_CYC);
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = val[i*8 +: 8];
        end
        return r;
    endfunction
    // search next non-skip entry after the current one, wrapping at size
    always_comb
    begin
        lim = (state_reg.act_size == 7'h00) ? 7'h01 : state_reg.act_size;
        nxt = state_reg.index;
        wrapped = 1'b0;
        skip_found = 1'b0;
        cand = state_reg.index;
        k = 7'h00;
        for (int i = 1; i <= `RXHOP_TABLE_DEPTH; i++)
        begin
            k = 7'(({1'b0, state_reg.index} + 7'(i)) % lim);
            cand = k[5:0];
            if (!skip_found && hop_table[cand] != `RXHOP_SKIP_MARK)
            begin
                skip_found = 1'b1;
                nxt = cand;
                wrapped = (cand <= state_reg.index);
            end
        end
        first_idx = 6'h00;
        first_found = 1'b0;
        for (int i = `RXHOP_TABLE_DEPTH - 1; i >= 0; i--)
        begin
            // start entry is searched with the size this command latches
            if (7'(i) < state_reg.table_size && hop_table[i] != `RXHOP_SKIP_MARK)
            begin
                first_found = 1'b1;
                first_idx = 6'(i);
            end
        end
    end
    // conditions: raw mode limits to rssi only, rssi compared unaveraged
    always_comb
    begin
        met_rssi = state_reg.act_ctrl[`RXHOP_CTRL_RSSI_BIT];
        met_pre = state_reg.act_ctrl[`RXHOP_CTRL_PRE_BIT] && packet_mode
            && preamble_timeout;
        met_sync = state_reg.act_ctrl[`RXHOP_CTRL_SYNC_BIT] && packet_mode
            && sync_timeout;
    end
    assign wr_fire = state_reg.awdone && state_reg.wdone && !state_reg.bvalid;
    always_comb
    begin
        rd_ok = 1'b1;
        rd_word = 32'h0000_0000;
        if (s_axi_araddr == `RXHOP_OFF_INTEGER)
            rd_word = {24'h000000, state_reg.integer_divide_value};
        else if (s_axi_araddr == `RXHOP_OFF_FRACTION)
            rd_word = {12'h000, state_reg.fractional_divide_value};
        else if (s_axi_araddr == `RXHOP_OFF_STEP)
            rd_word = {16'h0000, state_reg.step_upper, state_reg.step_lower};
        else if (s_axi_araddr == `RXHOP_OFF_TABLE_SIZE)
            rd_word = {25'h0000000, state_reg.table_size};
        else if (s_axi_araddr == `RXHOP_OFF_HOP_CTRL)
            rd_word = {28'h0000000, state_reg.hop_ctrl};
        else if (s_axi_araddr == `RXHOP_OFF_THRESHOLD)
            rd_word = {24'h000000, state_reg.signal_strength_threshold};
        else if (s_axi_araddr == `RXHOP_OFF_COMMAND)
            rd_word = {24'h000000, state_reg.channel};
        else if (s_axi_araddr == `RXHOP_OFF_FAST_HOP)
            rd_word = {16'h0000, state_reg.vco_calibration_count};
        else if (s_axi_araddr == `RXHOP_OFF_STATUS)
            rd_word = {16'h0000, state_reg.channel, 2'h0, state_reg.index};
        else if (s_axi_araddr == `RXHOP_OFF_FREQ_WORD)
            rd_word = tune.freq_word[31:0];
        else if (s_axi_araddr == `RXHOP_OFF_GPIO_CFG)
            rd_word = {31'h00000000, state_reg.gpio_en};
        else if (s_axi_araddr >= `RXHOP_OFF_TABLE_BASE && s_axi_araddr <= `RXHOP_OFF_TABLE_END)
            rd_word = {24'h000000, hop_table[s_axi_araddr[7:2]]};
        else
            rd_ok = 1'b0;
    end
    always_comb
    begin
        state_next = state_reg;
        tbl_we = 1'b0;
        tbl_waddr = state_reg.awaddr[7:2];
        tbl_wdata = state_reg.wdata[7:0];
        state_next.load = 1'b0;
        if (s_axi_awvalid && !state_reg.awdone)
        begin
            state_next.awdone = 1'b1;
            state_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !state_reg.wdone)
        begin
            state_next.wdone = 1'b1;
            state_next.wdata = s_axi_wdata;
            state_next.wstrb = s_axi_wstrb;
        end
        if (state_reg.bvalid && s_axi_bready)
            state_next.bvalid = 1'b0;
        if (state_reg.rvalid && s_axi_rready)
            state_next.rvalid = 1'b0;
        if (s_axi_arvalid && !state_reg.rvalid)
        begin
            state_next.rvalid = 1'b1;
            state_next.rdata = rd_word;
            state_next.rresp = rd_ok ? 2'b00 : 2'b10;
        end
        // hop sequencer
        case (state_reg.fsm)
            rxhop_pkg::RXHOP_IDLE:
            begin
                state_next.timer = 16'h0000;
            end
            rxhop_pkg::RXHOP_SETTLE:
            begin
                // synth settles; auto hop budget or shorter fast hop budget
                if (state_reg.timer >= (state_reg.fast ? fast_cyc : auto_cyc) - 16'h0001)
                begin
                    state_next.timer = 16'h0000;
                    state_next.fsm = rxhop_pkg::RXHOP_LISTEN;
                end
                else
                    state_next.timer = state_reg.timer + 16'h0001;
            end
            rxhop_pkg::RXHOP_LISTEN:
            begin
                if (state_reg.act_ctrl[`RXHOP_CTRL_EN_BIT])
                begin
                    // first met condition wins; rssi is evaluated every cycle
                    if (met_rssi && current_rssi > state_reg.signal_strength_threshold)
                        state_next.fsm = rxhop_pkg::RXHOP_STAY;
                    else if ((met_rssi && current_rssi <= state_reg.signal_strength_threshold)
                        || met_pre || met_sync)
                    begin
                        state_next.index = nxt;
                        state_next.channel = hop_table[nxt];
                        state_next.load = 1'b1;
                        state_next.fast = 1'b0;
                        state_next.fsm = rxhop_pkg::RXHOP_SETTLE;
                        if (state_reg.gpio_en)
                            state_next.gpio = state_reg.gpio ^ 1'b1 ^ (wrapped ? 1'b1 : 1'b0)
                                ^ (wrapped ? 1'b1 : 1'b0);
                        if (state_reg.gpio_en && wrapped)
                            state_next.gpio = state_reg.gpio;
                    end
                end
            end
            rxhop_pkg::RXHOP_STAY:
            begin
                // resume hopping once the signal is gone and no packet holds us
                if (current_rssi <= state_reg.signal_strength_threshold && !packet_valid)
                    state_next.fsm = rxhop_pkg::RXHOP_LISTEN;
            end
            default:
            begin
                state_next.timer = 16'h0000;
            end
        endcase
        if (wr_fire)
        begin
            state_next.awdone = 1'b0;
            state_next.wdone = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = 2'b00;
            if (state_reg.awaddr == `RXHOP_OFF_INTEGER)
                state_next.integer_divide_value = 8'(merge(32'(state_reg.integer_divide_value),
                    state_reg.wdata, state_reg.wstrb));
            else if (state_reg.awaddr == `RXHOP_OFF_FRACTION)
                state_next.fractional_divide_value = 20'(merge(
                    32'(state_reg.fractional_divide_value), state_reg.wdata, state_reg.wstrb));
            else if (state_reg.awaddr == `RXHOP_OFF_STEP)
            begin
                if (state_reg.wstrb[1])
                    state_next.step_upper = state_reg.wdata[15:8];
                if (state_reg.wstrb[0])
                    state_next.step_lower = state_reg.wdata[7:0];
            end
            else if (state_reg.awaddr == `RXHOP_OFF_TABLE_SIZE && state_reg.wstrb[0])
                state_next.table_size = (state_reg.wdata[6:0] > 7'h40) ? 7'h40
                    : state_reg.wdata[6:0];
            else if (state_reg.awaddr == `RXHOP_OFF_HOP_CTRL && state_reg.wstrb[0])
                state_next.hop_ctrl = state_reg.wdata[3:0];
            else if (state_reg.awaddr == `RXHOP_OFF_THRESHOLD && state_reg.wstrb[0])
                state_next.signal_strength_threshold = state_reg.wdata[7:0];
            else if (state_reg.awaddr == `RXHOP_OFF_GPIO_CFG && state_reg.wstrb[0])
                state_next.gpio_en = state_reg.wdata[0];
            else if (state_reg.awaddr == `RXHOP_OFF_FAST_HOP)
            begin
                // host supplies the calibration count; no computation here
                state_next.vco_calibration_count = state_reg.wdata[15:0];
                state_next.channel = state_reg.wdata[23:16];
                state_next.fast = 1'b1;
                state_next.load = 1'b1;
                state_next.timer = 16'h0000;
                state_next.fsm = rxhop_pkg::RXHOP_SETTLE;
            end
            else if (state_reg.awaddr == `RXHOP_OFF_COMMAND)
            begin
                // channel byte lane written only when the argument is given
                if (state_reg.wstrb[1])
                    state_next.channel = state_reg.wdata[15:8];
                state_next.load = 1'b1;
                state_next.timer = 16'h0000;
                state_next.fast = 1'b0;
                if (state_reg.wdata[1:0] == `RXHOP_CMD_RX)
                begin
                    state_next.act_size = state_reg.table_size;
                    state_next.act_ctrl = state_reg.hop_ctrl;
                    state_next.index = first_found ? first_idx : 6'h00;
                    state_next.fsm = rxhop_pkg::RXHOP_SETTLE;
                end
                else if (state_reg.wdata[1:0] == `RXHOP_CMD_TX)
                    state_next.fsm = rxhop_pkg::RXHOP_TX;
                else if (state_reg.wdata[1:0] == `RXHOP_CMD_IDLE)
                begin
                    state_next.load = 1'b0;
                    state_next.fsm = rxhop_pkg::RXHOP_IDLE;
                end
            end
            else if (state_reg.awaddr >= `RXHOP_OFF_TABLE_BASE
                && state_reg.awaddr <= `RXHOP_OFF_TABLE_END)
                tbl_we = state_reg.wstrb[0];
            else if (state_reg.awaddr != `RXHOP_OFF_STATUS
                && state_reg.awaddr != `RXHOP_OFF_FREQ_WORD)
                state_next.bresp = 2'b10;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= '0;
            state_reg.table_size <= `RXHOP_RST_TABLE_SIZE;
            state_reg.act_size <= `RXHOP_RST_TABLE_SIZE;
            state_reg.channel <= `RXHOP_RST_CHANNEL;
            state_reg.fsm <= rxhop_pkg::RXHOP_IDLE;
        end
        else
            state_reg <= state_next;
    end
    // table kept without reset so it maps to plain memory
    always_ff @(posedge aclk)
    begin
        if (tbl_we)
            hop_table[tbl_waddr] <= tbl_wdata;
    end
    assign s_axi_awready = !state_reg.awdone;
    assign s_axi_wready = !state_reg.wdone;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = !state_reg.rvalid;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign synth_freq_word = tune.freq_word;
    assign synth_load = state_reg.load;
    assign vco_calibration_count = state_reg.vco_calibration_count;
    assign vco_count_use = state_reg.fast;
    assign rx_active = (state_reg.fsm == rxhop_pkg::RXHOP_LISTEN)
        || (state_reg.fsm == rxhop_pkg::RXHOP_STAY);
    assign tx_active = (state_reg.fsm == rxhop_pkg::RXHOP_TX);
    assign hop_gpio = state_reg.gpio;
endmodule // rxhop_ctrl

/* rtl/rxhop_freq_calc.sv */
// synthesizer divide word: base from integer and fraction plus channel times step
`timescale 1ns/1ps
module rxhop_freq_calc
(
    input wire logic aclk,
    input wire logic aresetn,
    rxhop_tune_if.calc tune
);
    typedef struct packed {
        logic [39:0] freq_word;
    } rxhop_calc_state_t;
    rxhop_calc_state_t state_reg;
    rxhop_calc_state_t state_next;
    logic [39:0] base;
    logic [39:0] offset;
    // word is in units of 2^-19 of the integer step; scaling by 2*xtal/outdiv is analog-side
    always_comb
    begin
        // fraction is 20 bits wide so the host can keep it between 1 and 2
        base = {13'h0000, tune.integer_divide_value, 19'h00000}
            + {20'h00000, tune.fractional_divide_value};
        offset = {16'h0000, 24'(tune.channel) * 24'(tune.step)};
        state_next.freq_word = base + offset;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end
    assign tune.freq_word = state_reg.freq_word;
endmodule // rxhop_freq_calc

/* rtl/rxhop_pkg.sv */
// types shared by the rx hop control block
package rxhop_pkg;
    typedef enum logic [2:0] {
        RXHOP_IDLE,
        RXHOP_SETTLE,
        RXHOP_LISTEN,
        RXHOP_STAY,
        RXHOP_TX
    } rxhop_state_t;
endpackage

/* rtl/rxhop_regs.svh */
// register offsets, field positions, reset values and timing counts for rx hop control
`ifndef RXHOP_REGS_SVH
`define RXHOP_REGS_SVH
`define RXHOP_OFF_INTEGER     12'h000
`define RXHOP_OFF_FRACTION    12'h004
`define RXHOP_OFF_STEP        12'h008
`define RXHOP_OFF_TABLE_SIZE  12'h00C
`define RXHOP_OFF_HOP_CTRL    12'h010
`define RXHOP_OFF_THRESHOLD   12'h014
`define RXHOP_OFF_COMMAND     12'h018
`define RXHOP_OFF_FAST_HOP    12'h01C
`define RXHOP_OFF_STATUS      12'h020
`define RXHOP_OFF_FREQ_WORD   12'h024
`define RXHOP_OFF_GPIO_CFG    12'h028
`define RXHOP_OFF_TABLE_BASE  12'h100
`define RXHOP_OFF_TABLE_END   12'h1FC
`define RXHOP_FRAC_BITS       19
`define RXHOP_SKIP_MARK       8'hFF
`define RXHOP_TABLE_DEPTH     64
`define RXHOP_CTRL_RSSI_BIT   0
`define RXHOP_CTRL_PRE_BIT    1
`define RXHOP_CTRL_SYNC_BIT   2
`define RXHOP_CTRL_EN_BIT     3
`define RXHOP_CMD_RX          2'h1
`define RXHOP_CMD_TX          2'h2
`define RXHOP_CMD_IDLE        2'h0
`define RXHOP_RST_TABLE_SIZE  7'h01
`define RXHOP_RST_CHANNEL     8'h00
`define RXHOP_CLK_MHZ         100
`define RXHOP_AUTO_HOP_NS     115000
`define RXHOP_FAST_HOP_NS     75000
`define RXHOP_AUTO_HOP_CYC    ((`RXHOP_AUTO_HOP_NS * `RXHOP_CLK_MHZ) / 1000)
`define RXHOP_FAST_HOP_CYC    ((`RXHOP_FAST_HOP_NS * `RXHOP_CLK_MHZ) / 1000)
`endif

/* rtl/rxhop_tune_if.sv */
// carrier between the hop sequencer and the frequency calculator
`timescale 1ns/1ps
interface rxhop_tune_if;
    logic [7:0] integer_divide_value;
    logic [19:0] fractional_divide_value;
    logic [15:0] step;
    logic [7:0] channel;
    logic [39:0] freq_word;
    modport calc (input integer_divide_value, input fractional_divide_value, input step,
        input channel, output freq_word);
    modport ctrl (output integer_divide_value, output fractional_divide_value, output step,
        output channel, input freq_word);
endinterface

/* verification/rxhop_asserts.sv */
// port assertions for rx hop control
`timescale 1ns/1ps
module rxhop_asserts
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic synth_load,
    input wire logic rx_active,
    input wire logic tx_active,
    input wire logic hop_gpio
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    // a stalled bready keeps the answer standing, which is legal
    sequence wr_done;
        s_axi_bvalid ##1 (!s_axi_bvalid || !$past(s_axi_bready));
    endsequence
    a_write_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 wr_done)
        else $error("write answer missing or held too long");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer missing");
    a_read_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_load_once: assert property (synth_load |=> !synth_load)
        else $error("tune strobe too long");
    a_rx_tx_excl: assert property (!(rx_active && tx_active))
        else $error("receive and transmit together");
    a_gpio_in_rx: assert property ($changed(hop_gpio) |-> rx_active || $past(rx_active))
        else $error("gpio toggled outside receive");
    a_reset_quiet: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> !rx_active && !tx_active && !hop_gpio && !synth_load)
        else $error("outputs active after reset");
    a_no_idle_b: assert property (!s_axi_bvalid && (s_axi_awready || s_axi_wready)
        |=> !s_axi_bvalid)
        else $error("write answer without request");
endmodule // rxhop_asserts
bind rxhop_ctrl rxhop_asserts rxhop_asserts_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .synth_load(synth_load), .rx_active(rx_active), .tx_active(tx_active),
    .hop_gpio(hop_gpio));

/* verification/rxhop_ctrl_tb.sv */
// self-checking bench for rx hop control
`timescale 1ns/1ps
`include "rxhop_regs.svh"
module rxhop_ctrl_tb;
    localparam logic [39:0] BASE = {13'h0, 8'h20, 19'h0} + 40'hC0000;
    logic aclk = 1'h0, aresetn = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [7:0] current_rssi;
    logic preamble_timeout, sync_timeout, packet_valid, packet_mode, g;
    logic [39:0] synth_freq_word, strong_word = 40'hFFFFFFFFFF;
    logic synth_load, vco_count_use, rx_active, tx_active, hop_gpio;
    logic [15:0] vco_calibration_count;
    int err_total = 0, comparisons = 0, n;
    rxhop_ctrl rxhop_ctrl_inst (.*);
    rxhop_modem_model rxhop_modem_model_inst (.*);
    initial forever #5 aclk = ~aclk;
    function automatic logic [39:0] w(input logic [7:0] c);
        return BASE + {32'h0, c} * 40'h100;
    endfunction
    task end_sim;
        if (err_total == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    // bready and rready stay high, so answers are taken at once
    task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic da, dw;
        da = 1'h0;
        dw = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(da && dw))
        begin
            @(negedge aclk);
            if (s_axi_awready) da = 1'h1;
            if (s_axi_wready) dw = 1'h1;
            @(posedge aclk);
            if (da) s_axi_awvalid <= 1'h0;
            if (dw) s_axi_wvalid <= 1'h0;
        end
        @(negedge aclk);
        while (!s_axi_bvalid) @(negedge aclk);
        rs = s_axi_bresp;
        @(posedge aclk);
    endtask
    task rdw(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        @(negedge aclk);
        while (!s_axi_arready) @(negedge aclk);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        @(negedge aclk);
        while (!s_axi_rvalid) @(negedge aclk);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge aclk);
    endtask
    task hop(input logic [7:0] ch, input logic [31:0] st, input logic tg);
        g = hop_gpio;
        n = 0;
        @(negedge aclk);
        while (!synth_load)
        begin
            @(negedge aclk);
            n++;
        end
        repeat (4) @(posedge aclk);
        chk(synth_freq_word, w(ch));
        chk(n <= `RXHOP_AUTO_HOP_CYC + 16, 1'h1);
        chk(hop_gpio, g ^ tg);
        rdw(`RXHOP_OFF_STATUS);
        chk(rd, st);
    endtask
    initial
    begin
        repeat (70000) @(posedge aclk);
        err_total++;
        end_sim;
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rdw(`RXHOP_OFF_COMMAND);
        chk(rd, 32'h0);
        rdw(`RXHOP_OFF_TABLE_SIZE);
        chk(rd, 32'h1);
        rdw(12'h030);
        chk(rs, 2'h2);
        wr(12'h030, 32'h0, 4'hF);
        chk(rs, 2'h2);
        wr(`RXHOP_OFF_INTEGER, 32'h20, 4'hF);
        wr(`RXHOP_OFF_FRACTION, 32'hC0000, 4'hF);
        wr(`RXHOP_OFF_STEP, 32'h100, 4'hF);
        wr(`RXHOP_OFF_COMMAND, 32'h0502, 4'h3);
        repeat (4) @(posedge aclk);
        chk(synth_freq_word, w(8'h05));
        chk(tx_active, 1'h1);
        wr(`RXHOP_OFF_COMMAND, 32'h0, 4'h1);
        // channel byte not strobed, so the old channel must stay
        wr(`RXHOP_OFF_COMMAND, 32'h0902, 4'h1);
        repeat (4) @(posedge aclk);
        chk(synth_freq_word, w(8'h05));
        wr(`RXHOP_OFF_COMMAND, 32'h0, 4'h1);
        wr(`RXHOP_OFF_TABLE_SIZE, 32'h3, 4'hF);
        wr(`RXHOP_OFF_TABLE_BASE, 32'hFF, 4'hF);
        wr(`RXHOP_OFF_TABLE_BASE + 12'h4, 32'h2, 4'hF);
        wr(`RXHOP_OFF_TABLE_BASE + 12'h8, 32'h7, 4'hF);
        wr(`RXHOP_OFF_HOP_CTRL, 32'hF, 4'hF);
        wr(`RXHOP_OFF_THRESHOLD, 32'h40, 4'hF);
        wr(`RXHOP_OFF_GPIO_CFG, 32'h1, 4'hF);
        strong_word <= w(8'h07);
        wr(`RXHOP_OFF_COMMAND, 32'h0201, 4'h3);
        repeat (8) @(posedge aclk);
        hop(8'h07, 32'h0702, 1'h1);
        repeat (12000) @(posedge aclk);
        chk(synth_freq_word, w(8'h07));
        strong_word <= w(8'h03);
        hop(8'h02, 32'h0201, 1'h0);
        hop(8'h07, 32'h0702, 1'h1);
        wr(`RXHOP_OFF_FAST_HOP, 32'h0003_1234, 4'hF);
        repeat (4) @(posedge aclk);
        chk(vco_calibration_count, 16'h1234);
        chk(vco_count_use, 1'h1);
        chk(synth_freq_word, w(8'h03));
        n = 0;
        while (!rx_active)
        begin
            @(negedge aclk);
            n++;
        end
        chk(n <= `RXHOP_FAST_HOP_CYC, 1'h1);
        @(posedge aclk);
        // timeouts count only with packet handling, so no hop may follow
        wr(`RXHOP_OFF_HOP_CTRL, 32'hE, 4'hF);
        wr(`RXHOP_OFF_COMMAND, 32'h0201, 4'h3);
        repeat (11600) @(posedge aclk);
        chk(rx_active, 1'h1);
        chk(synth_freq_word, w(8'h02));
        end_sim;
    end
endmodule // rxhop_ctrl_tb

/* verification/rxhop_modem_model.sv */
// modem front end model: strength by tuned word, raw mode timeouts
`timescale 1ns/1ps
module rxhop_modem_model
(
    input wire logic aclk,
    input wire logic [39:0] synth_freq_word,
    input wire logic [39:0] strong_word,
    output logic [7:0] current_rssi = 8'h10,
    output logic preamble_timeout = 1'h0,
    output logic sync_timeout = 1'h0,
    output logic packet_valid = 1'h0,
    output logic packet_mode = 1'h0
);
    // fresh sample each cycle, nothing averaged
    always @(posedge aclk)
    begin
        current_rssi <= (synth_freq_word == strong_word) ? 8'hA0 : 8'h10;
        // timeouts raised in raw mode deliberately: they must not count
        preamble_timeout <= 1'h1;
        sync_timeout <= 1'h1;
        packet_valid <= 1'h0;
        packet_mode <= 1'h0;
    end
endmodule // rxhop_modem_model
